// *** core/buck_sequencer.sv ***
// Startup, thermal and hiccup sequencing for the buck controller.
`timescale 1ns/100ps
import seq_pkg::*;

module buck_sequencer import seq_pkg::*; #(
    parameter int unsigned DETECT_CNT = DETECT_CYCLES,
    parameter int unsigned IDLE_CNT   = IDLE_CYCLES,
    parameter int unsigned SS_CNT     = SOFT_START_CYCLES,
    parameter int unsigned VIOL_MAX   = VIOLATION_LIMIT
) (
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    // Analog comparator inputs, asynchronous.
    input  wire logic       over_temp_in,
    input  wire logic       temp_below_release_in,
    input  wire logic       current_limit_in,
    input  wire logic       comp_fault_in,
    // Resistor detect converter.
    input  wire logic [1:0] detect_code_in,
    input  wire logic       detect_valid_in,
    // Drive and status outputs.
    output drive_cmd_t      drive_out,
    output logic [1:0]      gain_code_out,
    output logic [4:0]      sense_gain_out,
    output logic            thermal_shutdown_out,
    output logic            detect_done_out,
    output logic            powered_down_out
);

    localparam int unsigned CW = 32;

    analog_flags_t flags_s;
    logic [3:0]    flags_raw;
    logic [3:0]    flags_vec;
    logic [2:0]    code_s;
    logic          viol_pulse;

    seq_state_t    state_r;
    seq_state_t    state_nxt;
    logic [CW-1:0] timer_r;
    logic [CW-1:0] timer_nxt;
    logic [5:0]    viol_r;
    logic [5:0]    viol_nxt;
    logic          restart_r;
    logic          restart_nxt;
    logic          retry_r;
    logic          retry_nxt;
    logic          valid_seen_r;
    logic          valid_seen_nxt;
    logic [1:0]    code_r;
    logic [1:0]    code_nxt;
    logic [4:0]    gain_r;
    logic [4:0]    gain_nxt;
    drive_cmd_t    drive_r;
    drive_cmd_t    drive_nxt;

    // Comparator levels cross into the clock domain.
    assign flags_raw = {over_temp_in, temp_below_release_in, current_limit_in, comp_fault_in};

    sync_2ff #(.WIDTH(4)) u_sync_flags (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .async_in (flags_raw),
        .sync_out (flags_vec)
    );

    // Detect code and its valid strobe also come from the analog side.
    sync_2ff #(.WIDTH(3)) u_sync_code (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .async_in ({detect_valid_in, detect_code_in}),
        .sync_out (code_s)
    );

    assign flags_s = analog_flags_t'(flags_vec);

    edge_rise u_viol_edge (
        .clock_in  (clock_in),
        .nrst_in   (nrst_in),
        .level_in  (flags_s.current_limit),
        .pulse_out (viol_pulse)
    );

    // Gain lookup from the two-bit code.
    function automatic logic [4:0] gain_of(input logic [1:0] code);
        logic [4:0] g;
        g = GAIN_3;
        case (code)
            CODE_47K:  g = GAIN_3;
            CODE_22K:  g = GAIN_6;
            CODE_OPEN: g = GAIN_12;
            default:   g = GAIN_24;
        endcase
        return g;
    endfunction

    // Sequencer next state, timers and counters.
    always_comb
    begin
        state_nxt   = state_r;
        timer_nxt   = timer_r;
        viol_nxt    = viol_r;
        restart_nxt = restart_r;
        retry_nxt   = retry_r;
        code_nxt    = code_r;
        gain_nxt    = gain_r;
        // Valid must stand on two edges so that skewed code bits have settled.
        valid_seen_nxt = code_s[2];
        if (flags_s.over_temp && state_r != ST_THERMAL && state_r != ST_DETECT)
        begin
            state_nxt = ST_THERMAL;
            timer_nxt = '0;
        end
        else
        begin
            case (state_r)
                ST_DETECT:
                begin
                    // Detection window count.
                    // A code taken on the first valid edge could hold a bit caught mid-change.
                    if (timer_r >= CW'(DETECT_CNT - 1) && code_s[2] && valid_seen_r)
                    begin
                        code_nxt  = code_s[1:0];
                        gain_nxt  = gain_of(code_s[1:0]);
                        state_nxt = ST_SOFTSTART;
                        timer_nxt = '0;
                    end
                    else if (timer_r < CW'(DETECT_CNT - 1))
                        timer_nxt = timer_r + 1'b1;
                end
                ST_SOFTSTART:
                begin
                    if (restart_r && flags_s.comp_fault)
                    begin
                        state_nxt = ST_IDLE;
                        retry_nxt = 1'b1;
                        viol_nxt  = '0;
                        timer_nxt = '0;
                    end
                    else if (timer_r >= CW'(SS_CNT - 1))
                    begin
                        state_nxt   = ST_RUN;
                        restart_nxt = 1'b0;
                        retry_nxt   = 1'b0;
                        timer_nxt   = '0;
                    end
                    else
                        timer_nxt = timer_r + 1'b1;
                end
                ST_RUN:
                begin
                    if (viol_pulse)
                    begin
                        if (viol_r >= 6'(VIOL_MAX - 1))
                        begin
                            state_nxt = ST_IDLE;
                            viol_nxt  = '0;
                            timer_nxt = '0;
                        end
                        else
                            viol_nxt = viol_r + 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (timer_r >= CW'(IDLE_CNT - 1))
                    begin
                        timer_nxt = '0;
                        if (retry_r)
                            state_nxt = ST_POWERDOWN;
                        else
                        begin
                            state_nxt   = ST_SOFTSTART;
                            restart_nxt = 1'b1;
                        end
                    end
                    else
                        timer_nxt = timer_r + 1'b1;
                end
                ST_POWERDOWN:
                begin
                    // Power-down one idle period, then retry the ramp.
                    if (timer_r >= CW'(IDLE_CNT - 1))
                    begin
                        timer_nxt   = '0;
                        retry_nxt   = 1'b0;
                        restart_nxt = 1'b1;
                        state_nxt   = ST_SOFTSTART;
                    end
                    else
                        timer_nxt = timer_r + 1'b1;
                end
                ST_THERMAL:
                begin
                    if (flags_s.below_release && !flags_s.over_temp)
                    begin
                        state_nxt   = ST_SOFTSTART;
                        restart_nxt = 1'b0;
                        retry_nxt   = 1'b0;
                        viol_nxt    = '0;
                        timer_nxt   = '0;
                    end
                end
                default:
                begin
                    state_nxt = ST_DETECT;
                    timer_nxt = '0;
                end
            endcase
        end
    end

    // Drive commands from the next state, so outputs are registered.
    always_comb
    begin
        drive_nxt = '0;
        case (state_nxt)
            ST_DETECT:
                drive_nxt.detect_ref_en = 1'b1;
            ST_SOFTSTART:
            begin
                drive_nxt.switching_en    = 1'b1;
                drive_nxt.soft_start_en   = 1'b1;
                drive_nxt.high_side_drive = 1'b1;
                drive_nxt.low_side_drive  = 1'b1;
            end
            ST_RUN:
            begin
                drive_nxt.switching_en    = 1'b1;
                drive_nxt.high_side_drive = 1'b1;
                drive_nxt.low_side_drive  = 1'b1;
            end
            default:
                drive_nxt = '0;
        endcase
    end

    // State registers.
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r   <= ST_DETECT;
            timer_r   <= '0;
            viol_r    <= '0;
            restart_r <= 1'b0;
            retry_r   <= 1'b0;
            valid_seen_r <= 1'b0;
            code_r    <= CODE_RESET;
            gain_r    <= GAIN_3;
            drive_r   <= '{detect_ref_en: 1'b1, default: 1'b0};
        end
        else
        begin
            state_r   <= state_nxt;
            timer_r   <= timer_nxt;
            viol_r    <= viol_nxt;
            restart_r <= restart_nxt;
            retry_r   <= retry_nxt;
            valid_seen_r <= valid_seen_nxt;
            code_r    <= code_nxt;
            gain_r    <= gain_nxt;
            drive_r   <= drive_nxt;
        end
    end

    // Outputs.
    assign drive_out            = drive_r;
    assign gain_code_out        = code_r;
    assign sense_gain_out       = gain_r;
    assign thermal_shutdown_out = (state_r == ST_THERMAL);
    assign detect_done_out      = (state_r != ST_DETECT);
    assign powered_down_out     = (state_r == ST_POWERDOWN);

endmodule

// *** core/edge_rise.sv ***
// Rising edge detector that turns a level into a one-cycle pulse.
`timescale 1ns/100ps
module edge_rise (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic nrst_in,
    // Level in, pulse out.
    input  wire logic level_in,
    output logic      pulse_out
);

    logic prev_r;
    logic prev_nxt;

    // Remembers last cycle's level.
    always_comb
    begin
        prev_nxt = level_in;
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
            prev_r <= 1'b0;
        else
            prev_r <= prev_nxt;
    end

    // Pulse when the level goes high.
    assign pulse_out = level_in & ~prev_r;

endmodule

// *** core/sync_2ff.sv ***
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module sync_2ff #(
    parameter int unsigned WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    // Level crossing.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // The first stage feeds only the second stage.
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule

// *** include/seq_pkg.sv ***
// Shared constants, types and state codes for the buck sequencer.
package seq_pkg;

    // Clock rate in kHz, period 5 ns.
    localparam int unsigned CLK_KHZ          = 200000;
    // Detection time in microseconds and derived cycle count.
    localparam int unsigned DETECT_TIME_US   = 800;
    localparam int unsigned DETECT_CYCLES    = DETECT_TIME_US * (CLK_KHZ / 1000);
    // Idle interval in milliseconds and derived cycle count.
    localparam int unsigned IDLE_TIME_MS     = 6;
    localparam int unsigned IDLE_CYCLES      = IDLE_TIME_MS * CLK_KHZ;
    // Violations that trigger idle mode.
    localparam int unsigned VIOLATION_LIMIT  = 32;
    // Soft start length in cycles; no figure is given for it.
    localparam int unsigned SOFT_START_CYCLES = 4000;

    // Gain selection codes from the detect converter.
    localparam logic [1:0] CODE_47K  = 2'h0;
    localparam logic [1:0] CODE_22K  = 2'h1;
    localparam logic [1:0] CODE_OPEN = 2'h2;
    localparam logic [1:0] CODE_100K = 2'h3;
    // Gain value in V/V per code.
    localparam logic [4:0] GAIN_3    = 5'h03;
    localparam logic [4:0] GAIN_6    = 5'h06;
    localparam logic [4:0] GAIN_12   = 5'h0C;
    localparam logic [4:0] GAIN_24   = 5'h18;
    // Reset value of the latched code.
    localparam logic [1:0] CODE_RESET = 2'h0;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_DETECT    = 3'b000,
        ST_SOFTSTART = 3'b001,
        ST_RUN       = 3'b010,
        ST_IDLE      = 3'b011,
        ST_POWERDOWN = 3'b100,
        ST_THERMAL   = 3'b101
    } seq_state_t;

    // Analog comparator indications after synchronisation.
    typedef struct packed {
        logic over_temp;
        logic below_release;
        logic current_limit;
        logic comp_fault;
    } analog_flags_t;

    // Drive commands to the gate driver stage.
    typedef struct packed {
        logic switching_en;
        logic high_side_drive;
        logic low_side_drive;
        logic detect_ref_en;
        logic soft_start_en;
    } drive_cmd_t;

endpackage

// *** sim/analog_stage_model.sv ***
// Behavioural model of the analog power stage facing the sequencer.
`timescale 1ns/100ps
module analog_stage_model import seq_pkg::*; (
    // Clock and reset.
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    // Commands from the sequencer and the bench.
    input  wire drive_cmd_t drive_in,
    input  wire logic [1:0] code_sel_in,
    input  wire logic [1:0] temp_zone_in,
    input  wire logic       fault_in,
    // Comparator and converter outputs.
    output logic            over_temp_out,
    output logic            below_release_out,
    output logic            current_limit_out,
    output logic            comp_fault_out,
    output logic [1:0]      detect_code_out,
    output logic            detect_valid_out
);
    logic lim_r;
    int   conv_cnt;

    initial lim_r = 1'b0;

    // converter needs reference: result settles a few cycles after the reference is forced.
    always @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
            conv_cnt <= 0;
        else if (drive_in.detect_ref_en && conv_cnt < 4)
            conv_cnt <= conv_cnt + 1;
    end

    // two-bit code: unsettled lines show the inverse so a stale code is never read.
    assign detect_valid_out  = (conv_cnt == 4);
    assign detect_code_out   = detect_valid_out ? code_sel_in : ~code_sel_in;
    // Zone 2 is above the trip point, zone 0 below the release point.
    assign over_temp_out     = (temp_zone_in == 2'h2);
    assign below_release_out = (temp_zone_in == 2'h0);
    // sensed current: only seen while the low-side switch is enabled.
    assign current_limit_out = lim_r & drive_in.low_side_drive;
    assign comp_fault_out    = fault_in & drive_in.soft_start_en;

    // Produces n separate overcurrent pulses, each long enough to pass the synchroniser.
    task viol(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock_in);
            #1 lim_r = 1'b1;
            repeat (3) @(posedge clock_in);
            #1 lim_r = 1'b0;
            repeat (2) @(posedge clock_in);
        end
    endtask
endmodule

// *** sim/seq_asserts.sv ***
// Port-level concurrent checks for the buck sequencer.
`timescale 1ns/100ps
module seq_asserts import seq_pkg::*; #(
    parameter int unsigned DETECT_CNT = 20,
    parameter int unsigned IDLE_CNT   = 50,
    parameter int unsigned SS_CNT     = 20,
    parameter int unsigned VIOL_MAX   = 32
) (
    // Clock and reset.
    input wire logic       clock_in,
    input wire logic       nrst_in,
    // Temperature comparators.
    input wire logic       over_temp_in,
    input wire logic       temp_below_release_in,
    // Drive and status outputs.
    input wire drive_cmd_t drive_out,
    input wire logic [1:0] gain_code_out,
    input wire logic [4:0] sense_gain_out,
    input wire logic       thermal_shutdown_out,
    input wire logic       detect_done_out,
    input wire logic       powered_down_out
);
    int unsigned off_cnt;
    int unsigned ss_cnt;

    default clocking dc @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    // Count cycles with switching off and cycles spent in soft start.
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            off_cnt <= 0;
            ss_cnt  <= 0;
        end
        else
        begin
            off_cnt <= drive_out.switching_en ? 0 : off_cnt + 1;
            ss_cnt  <= drive_out.soft_start_en ? ss_cnt + 1 : 0;
        end
    end

    a_detect_ref_first: assert property (!detect_done_out |-> drive_out.detect_ref_en
        && !drive_out.switching_en && !drive_out.soft_start_en) else $error("drive before detect");
    a_gain_map_table: assert property (sense_gain_out ==
        (gain_code_out == CODE_47K ? 5'h03 : gain_code_out == CODE_22K ? 5'h06 :
        gain_code_out == CODE_OPEN ? 5'h0C : 5'h18)) else $error("gain mapping wrong");
    a_gain_code_held: assert property (detect_done_out && $past(detect_done_out)
        |-> $stable(gain_code_out)) else $error("gain code changed");
    a_thermal_drives_off: assert property (thermal_shutdown_out
        |-> drive_out[4:2] == 3'h0) else $error("drives on in thermal");
    a_thermal_entry_time: assert property ((detect_done_out && over_temp_in)[*4]
        |-> ##[0:2] thermal_shutdown_out) else $error("thermal entry late");
    a_thermal_hold_hot: assert property ((!temp_below_release_in)[*4]
        ##0 thermal_shutdown_out |=> thermal_shutdown_out) else $error("thermal left early");
    a_powerdown_drives_off: assert property (powered_down_out
        |-> !drive_out.high_side_drive && !drive_out.low_side_drive) else $error("drives on");
    a_idle_min_length: assert property ($rose(drive_out.switching_en)
        && $past(detect_done_out) && !$past(thermal_shutdown_out)
        |-> off_cnt >= IDLE_CNT - 1) else $error("idle too short");
    a_soft_start_length: assert property ($fell(drive_out.soft_start_en)
        && drive_out.switching_en |-> ss_cnt inside {[SS_CNT-1:SS_CNT+1]})
        else $error("soft start length wrong");
endmodule

bind buck_sequencer seq_asserts #(
    .DETECT_CNT(DETECT_CNT),
    .IDLE_CNT  (IDLE_CNT),
    .SS_CNT    (SS_CNT),
    .VIOL_MAX  (VIOL_MAX)
) u_seq_asserts (
    .clock_in             (clock_in),
    .nrst_in              (nrst_in),
    .over_temp_in         (over_temp_in),
    .temp_below_release_in(temp_below_release_in),
    .drive_out            (drive_out),
    .gain_code_out        (gain_code_out),
    .sense_gain_out       (sense_gain_out),
    .thermal_shutdown_out (thermal_shutdown_out),
    .detect_done_out      (detect_done_out),
    .powered_down_out     (powered_down_out)
);

// *** sim/tb_top.sv ***
// Self-checking testbench for the buck sequencer.
`timescale 1ns/100ps
module tb_top import seq_pkg::*;;
    localparam int unsigned DET = 20;
    localparam int unsigned IDL = 50;
    localparam int unsigned SSC = 20;
    localparam int SS = 0, LOW = 2, HIGH = 3, SW = 4, DONE = 5, TH = 6, PD = 7;
    logic       clock_in, nrst_in, fault;
    logic [1:0] code_sel, temp_zone, det_code, gain_code_out;
    logic       over_temp, below_rel, cur_lim, comp_fault, det_valid, th, done, pd;
    logic [4:0] sense_gain_out;
    drive_cmd_t drive_out;
    wire  [7:0] flags = {pd, th, done, drive_out};
    int         err_count, samples_checked, cycles, n;

    buck_sequencer #(.DETECT_CNT(DET), .IDLE_CNT(IDL), .SS_CNT(SSC), .VIOL_MAX(32)) dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .over_temp_in(over_temp),
        .temp_below_release_in(below_rel), .current_limit_in(cur_lim),
        .comp_fault_in(comp_fault), .detect_code_in(det_code), .detect_valid_in(det_valid),
        .drive_out(drive_out), .gain_code_out(gain_code_out), .sense_gain_out(sense_gain_out),
        .thermal_shutdown_out(th), .detect_done_out(done), .powered_down_out(pd));

    analog_stage_model u_pm (
        .clock_in(clock_in), .nrst_in(nrst_in), .drive_in(drive_out), .code_sel_in(code_sel),
        .temp_zone_in(temp_zone), .fault_in(fault), .over_temp_out(over_temp),
        .below_release_out(below_rel), .current_limit_out(cur_lim), .comp_fault_out(comp_fault),
        .detect_code_out(det_code), .detect_valid_out(det_valid));

    // Clock at 200 MHz and a cycle ceiling that cuts a hang short.
    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_count++;
            summarize();
        end
    end

    task summarize();
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask
    // Waits for one status bit under a bound; running out counts as a mismatch.
    task wait_flag(input int idx, input logic val, input int lim, output int cnt);
        cnt = 0;
        while (flags[idx] !== val && cnt < lim)
        begin
            cyc(1);
            cnt++;
        end
        check("wait_flag", {7'h00, cnt < lim}, 8'h01);
    endtask
    function automatic logic [4:0] exp_gain(input logic [1:0] c);
        return (c == 2'h0) ? 5'h03 : (c == 2'h1) ? 5'h06 : (c == 2'h2) ? 5'h0C : 5'h18;
    endfunction

    // Power-up with one resistor code, detection, latching and soft start into run.
    task t_startup(input logic [1:0] code);
        cyc(1);
        code_sel = code;
        nrst_in = 1'b0;
        cyc(10);
        nrst_in = 1'b1;
        check("ref_forced", flags[1], 1);
        check("switch_off", flags[SW], 0);
        wait_flag(DONE, 1, DET + 20, n);
        check("detect_len", n >= DET - 4, 1);
        check("ss_start", {flags[SW], flags[SS], flags[1]}, 8'h06);
        check("gain_code", gain_code_out, code);
        check("sense_gain", sense_gain_out, exp_gain(code));
        code_sel = ~code;
        cyc(10);
        check("gain_held", gain_code_out, code);
        wait_flag(SS, 0, SSC + 10, n);
        check("run", flags[SW], 1);
    endtask

    // Overcurrent hiccup: idle, restart, power-down while faulted, then recovery.
    task t_hiccup();
        u_pm.viol(31);
        cyc(6);
        check("no_idle_31", flags[SW], 1);
        u_pm.lim_r = 1'b1;
        wait_flag(SW, 0, 10, n);
        u_pm.lim_r = 1'b0;
        check("idle_off", flags[HIGH:LOW], 0);
        wait_flag(SW, 1, IDL + 10, n);
        check("idle_len", n inside {[IDL-2:IDL+1]}, 1);
        check("restart", flags[SS], 1);
        fault = 1'b1;
        wait_flag(PD, 1, SSC + IDL + 20, n);
        check("pd_off", flags[HIGH:LOW], 0);
        wait_flag(PD, 0, IDL + 10, n);
        check("pd_retry", flags[SS], 1);
        fault = 1'b0;
        wait_flag(SS, 0, SSC + 10, n);
        check("recovered", flags[SW], 1);
        u_pm.viol(31);
        cyc(6);
        check("count_cleared", flags[SW], 1);
    endtask

    // Thermal trip, hysteresis hold in the middle zone and release.
    task t_thermal();
        temp_zone = 2'h2;
        wait_flag(TH, 1, 10, n);
        check("th_drives", flags[SW:LOW], 0);
        temp_zone = 2'h1;
        cyc(30);
        check("th_hyst", flags[TH], 1);
        temp_zone = 2'h0;
        wait_flag(TH, 0, 10, n);
        check("th_resume", flags[SS], 1);
        wait_flag(SS, 0, SSC + 10, n);
        check("th_run", flags[SW], 1);
    endtask

    // Main sequence.
    initial
    begin
        nrst_in = 1'b0;
        code_sel = 2'h0;
        temp_zone = 2'h0;
        fault = 1'b0;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        for (int c = 0; c < 4; c++) t_startup(c[1:0]);
        t_hiccup();
        t_thermal();
        summarize();
    end
endmodule
